// ==== rtl/rts_defines.svh ====
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTS_OFS_SYNTH_TEST      6'h29
`define RTS_OFS_PRODUCTION_TEST 6'h2A
`define RTS_OFS_GAIN_CTRL_TEST  6'h2B
`define RTS_OFS_TEST_SETTING_2  6'h2C
`define RTS_OFS_TEST_SETTING_1  6'h2D
`define RTS_OFS_TEST_SETTING_0  6'h2E
`define RTS_OFS_PART_NUMBER     6'h30
`define RTS_OFS_SILICON_VERSION 6'h31
`define RTS_OFS_FREQ_OFFSET     6'h32
`define RTS_OFS_LINK_QUALITY    6'h33
`define RTS_OFS_SIGNAL_STRENGTH 6'h34
`define RTS_OFS_RADIO_STATE     6'h35

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RTS_RST_SYNTH_TEST      8'h59
`define RTS_RST_PRODUCTION_TEST 8'h7F
`define RTS_RST_GAIN_CTRL_TEST  8'h3F
`define RTS_RST_TEST_SETTING_2  8'h88
`define RTS_RST_TEST_SETTING_1  8'h31
`define RTS_RST_TEST_SETTING_0  8'h0B

// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define RTS_TEMP_SENSOR_ON      8'hBF
`define RTS_OSC_SEL_CAL_BIT     1
`define RTS_CRC_OK_BIT          7
`define RTS_HDR_READ_BIT        7
`define RTS_TEST_ENTRIES        6
`define RTS_CODE_SLEEP          5'h00
`define RTS_CODE_IDLE           5'h01
`define RTS_CODE_CRYSTAL_OFF    5'h02
`define RTS_CODE_RX             5'h0D
`define RTS_CODE_RX_OVERFLOW    5'h11
`define RTS_CODE_TX             5'h13
`define RTS_CODE_TX_UNDERFLOW   5'h16

`endif

// ==== rtl/rts_pkg.sv ====
`default_nettype none
package rts_pkg;

  typedef enum logic [2:0] {
    RTS_PH_HEADER = 3'h1,
    RTS_PH_DATA   = 3'h2,
    RTS_PH_DONE   = 3'h4
  } rts_phase_t;

  typedef logic [7:0] rts_byte_t;

endpackage
`default_nettype wire

// ==== rtl/rts_test_bank.sv ====
`include "rts_defines.svh"
`default_nettype none
module rts_test_bank
  import rts_pkg::*;
(
  input  wire logic      i_clk_sys,
  input  wire logic      i_resetn,
  input  wire logic      i_sleep_enter,
  input  wire logic      i_wr_en,
  input  wire logic [2:0] i_wr_idx,
  input  wire rts_byte_t i_wr_data,
  input  wire logic [2:0] i_rd_idx,
  output rts_byte_t      o_rd_data,
  output rts_byte_t      o_production_test,
  output rts_byte_t      o_test_setting_0
);

  rts_byte_t bank_r [`RTS_TEST_ENTRIES];
  rts_byte_t rd_data_r;

  // ----------------------------------------------------------------
  // Entries; sleep restores defaults and beats a host write
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RTS_TEST_ENTRIES; g++) begin : g_entry
      localparam rts_byte_t RST_VAL =
        (g == 0) ? `RTS_RST_SYNTH_TEST :
        (g == 1) ? `RTS_RST_PRODUCTION_TEST :
        (g == 2) ? `RTS_RST_GAIN_CTRL_TEST :
        (g == 3) ? `RTS_RST_TEST_SETTING_2 :
        (g == 4) ? `RTS_RST_TEST_SETTING_1 : `RTS_RST_TEST_SETTING_0;
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          bank_r[g] <= RST_VAL;
        end else if (i_sleep_enter) begin
          bank_r[g] <= RST_VAL;
        end else if (i_wr_en && (i_wr_idx == 3'(g))) begin
          bank_r[g] <= i_wr_data;
        end
      end

      a_sleep_restore: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        i_sleep_enter |=> (bank_r[g] == RST_VAL))
        else $error("test register not restored on sleep");
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_r <= 8'h00;
    end else if (i_rd_idx < 3'(`RTS_TEST_ENTRIES)) begin
      rd_data_r <= bank_r[i_rd_idx];
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign o_rd_data         = rd_data_r;
  assign o_production_test = bank_r[1];
  assign o_test_setting_0  = bank_r[5];

  c_sleep_restore: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_wr_en ##[1:50] i_sleep_enter);

endmodule
`default_nettype wire

// ==== rtl/rts_regs.sv ====
`include "rts_defines.svh"
`default_nettype none
module rts_regs
  import rts_pkg::*;
#(
  parameter rts_byte_t PART_NUMBER     = 8'hA5, // Arbitrary value
  parameter rts_byte_t SILICON_VERSION = 8'h5A  // Arbitrary value
)(
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  input  wire logic       i_chip_select_low,
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  output logic            o_miso,
  output logic            o_miso_oe_n,
  input  wire logic [4:0] i_radio_state_code,
  input  wire logic       i_sleep_enter,
  input  wire rts_byte_t  i_freq_offset,
  input  wire logic       i_mod_ask_ook,
  input  wire logic       i_crc_done,
  input  wire logic       i_crc_match,
  input  wire logic       i_rx_enter,
  input  wire logic       i_lqi_valid,
  input  wire logic [6:0] i_link_quality_value,
  input  wire rts_byte_t  i_signal_strength,
  output logic            o_wake_request,
  output logic            o_temp_sensor_en,
  output logic            o_osc_select_cal_enable
);

  rts_phase_t phase_r;
  logic       sclk_r;
  logic       cs_low_r;
  logic [3:0] bit_cnt_r;
  rts_byte_t  rx_shift_r;
  rts_byte_t  header_r;
  rts_byte_t  tx_shift_r;
  rts_byte_t  freq_r;
  logic       crc_ok_r;
  logic [6:0] lqi_r;
  rts_byte_t  signal_strength_r;
  logic       wake_r;
  logic       temp_en_r;
  logic       wr_en;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  rts_byte_t  bank_rd_data;
  rts_byte_t  production_test;
  rts_byte_t  test_setting_0;
  rts_byte_t  rd_mux;
  rts_byte_t  rx_byte_nxt;
  logic [4:0] state_read;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic [5:0] addr;
  logic       in_bank;

  // ----------------------------------------------------------------
  // Serial port edge detection
  // ----------------------------------------------------------------
  // Pins are taken as synchronous; SCLK must stay at least two
  // system clocks in each level so a read byte is ready in time.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_r   <= 1'b0;
      cs_low_r <= 1'b1;
    end else begin
      sclk_r   <= i_sclk;
      cs_low_r <= i_chip_select_low;
    end
  end

  assign sclk_rise   = !i_chip_select_low && i_sclk && !sclk_r;
  assign sclk_fall   = !i_chip_select_low && !i_sclk && sclk_r;
  assign cs_fall     = !i_chip_select_low && cs_low_r;
  assign rx_byte_nxt = {rx_shift_r[6:0], i_mosi};
  assign addr        = header_r[5:0];
  assign in_bank     = (addr >= `RTS_OFS_SYNTH_TEST) && (addr <= `RTS_OFS_TEST_SETTING_0);

  // ----------------------------------------------------------------
  // Frame sequencing: header byte, one data byte, rest ignored
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_r   <= RTS_PH_HEADER;
      bit_cnt_r <= 4'h0;
      rx_shift_r <= 8'h00;
      header_r  <= 8'h00;
    end else if (i_chip_select_low) begin
      phase_r   <= RTS_PH_HEADER;
      bit_cnt_r <= 4'h0;
    end else if (sclk_rise) begin
      rx_shift_r <= rx_byte_nxt;
      unique case (phase_r)
        RTS_PH_HEADER: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == 4'h7) begin
            header_r  <= rx_byte_nxt;
            bit_cnt_r <= 4'h0;
            phase_r   <= RTS_PH_DATA;
          end
        end
        RTS_PH_DATA: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == 4'h7) begin
            bit_cnt_r <= 4'h0;
            phase_r   <= RTS_PH_DONE;
          end
        end
        RTS_PH_DONE: begin
          bit_cnt_r <= 4'h0;
        end
        default: begin
          phase_r <= RTS_PH_HEADER;
        end
      endcase
    end
  end

  // Only the test bank takes writes; status offsets fall through
  assign wr_en  = sclk_rise && (phase_r == RTS_PH_DATA) && (bit_cnt_r == 4'h7)
                  && !header_r[`RTS_HDR_READ_BIT] && in_bank;
  assign wr_idx = 3'(addr - `RTS_OFS_SYNTH_TEST);
  assign rd_idx = in_bank ? 3'(addr - `RTS_OFS_SYNTH_TEST) : 3'h7;

  rts_test_bank u_test_bank (
    .i_clk_sys         (i_clk_sys),
    .i_resetn          (i_resetn),
    .i_sleep_enter     (i_sleep_enter),
    .i_wr_en           (wr_en),
    .i_wr_idx          (wr_idx),
    .i_wr_data         (rx_byte_nxt),
    .i_rd_idx          (rd_idx),
    .o_rd_data         (bank_rd_data),
    .o_production_test (production_test),
    .o_test_setting_0  (test_setting_0)
  );

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Sleep and crystal-off end as soon as chip select falls, so a
  // read can never see them; report idle in their place.
  always_comb begin
    state_read = i_radio_state_code;
    if ((i_radio_state_code == `RTS_CODE_SLEEP) || (i_radio_state_code == `RTS_CODE_CRYSTAL_OFF)) begin
      state_read = `RTS_CODE_IDLE;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (in_bank) begin
      rd_mux = bank_rd_data;
    end else begin
      unique case (addr)
        `RTS_OFS_PART_NUMBER:     rd_mux = PART_NUMBER;
        `RTS_OFS_SILICON_VERSION: rd_mux = SILICON_VERSION;
        `RTS_OFS_FREQ_OFFSET:     rd_mux = freq_r;
        `RTS_OFS_LINK_QUALITY:    rd_mux = {crc_ok_r, lqi_r};
        `RTS_OFS_SIGNAL_STRENGTH: rd_mux = signal_strength_r;
        `RTS_OFS_RADIO_STATE:     rd_mux = {3'b000, state_read};
        default:                  rd_mux = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // MISO: status byte during header, read byte after it
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_shift_r <= 8'h00;
    end else if (cs_fall) begin
      tx_shift_r <= {3'b000, state_read};
    end else if (sclk_fall) begin
      if ((phase_r == RTS_PH_DATA) && (bit_cnt_r == 4'h0)) begin
        tx_shift_r <= header_r[`RTS_HDR_READ_BIT] ? rd_mux : 8'h00;
      end else begin
        tx_shift_r <= {tx_shift_r[6:0], 1'b0};
      end
    end
  end

  assign o_miso      = tx_shift_r[7];
  assign o_miso_oe_n = i_chip_select_low;

  // ----------------------------------------------------------------
  // Status capture from the radio core
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      freq_r <= 8'h00;
    end else if (i_mod_ask_ook) begin
      freq_r <= 8'h00;
    end else begin
      freq_r <= i_freq_offset;
    end
  end

  // A match reported in the same cycle as a receive restart is kept
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      crc_ok_r <= 1'b0;
    end else if (i_crc_done) begin
      crc_ok_r <= i_crc_match;
    end else if (i_rx_enter) begin
      crc_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      lqi_r <= 7'h00;
    end else if (i_lqi_valid) begin
      lqi_r <= i_link_quality_value;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      signal_strength_r <= 8'h00;
    end else begin
      signal_strength_r <= i_signal_strength;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= cs_fall && ((i_radio_state_code == `RTS_CODE_SLEEP)
                || (i_radio_state_code == `RTS_CODE_CRYSTAL_OFF));
    end
  end

  // Sensor only usable in idle; the host owns restoring the default
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      temp_en_r <= 1'b0;
    end else begin
      temp_en_r <= (production_test == `RTS_TEMP_SENSOR_ON)
                   && (i_radio_state_code == `RTS_CODE_IDLE);
    end
  end

  assign o_wake_request          = wake_r;
  assign o_temp_sensor_en        = temp_en_r;
  assign o_osc_select_cal_enable = test_setting_0[`RTS_OSC_SEL_CAL_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_crc_match_set: assert property (i_crc_done && i_crc_match |=> crc_ok_r)
    else $error("CRC ok not set on match");
  a_crc_rx_clear: assert property (i_rx_enter && !i_crc_done |=> !crc_ok_r)
    else $error("CRC ok not cleared on receive entry");
  a_lqi_capture: assert property (i_lqi_valid |=> lqi_r == $past(i_link_quality_value))
    else $error("link quality not captured");
  a_freq_zero_ask: assert property (i_mod_ask_ook |=> freq_r == 8'h00)
    else $error("frequency offset nonzero under amplitude keying");
  a_freq_follow: assert property (!i_mod_ask_ook |=> freq_r == $past(i_freq_offset))
    else $error("frequency offset not tracked");
  a_signal_strength_follow: assert property (##1 signal_strength_r == $past(i_signal_strength))
    else $error("signal strength not tracked");
  a_state_hidden: assert property (state_read != `RTS_CODE_SLEEP
    && state_read != `RTS_CODE_CRYSTAL_OFF)
    else $error("sleep or crystal-off code visible");
  a_wake_on_select: assert property (cs_fall && (i_radio_state_code == `RTS_CODE_SLEEP)
    |=> o_wake_request)
    else $error("no wake request on chip select");
  a_temp_idle_only: assert property (o_temp_sensor_en |-> $past(i_radio_state_code) == `RTS_CODE_IDLE
    && $past(production_test) == `RTS_TEMP_SENSOR_ON)
    else $error("temperature sensor enabled outside idle or code");
  a_status_no_write: assert property (wr_en |-> addr < `RTS_OFS_PART_NUMBER)
    else $error("write reached a status offset");
  a_status_upper_zero: assert property (cs_fall |=> tx_shift_r[7:5] == 3'b000)
    else $error("status byte upper bits not zero");

  c_crc_ok: cover property (i_rx_enter ##[1:100] crc_ok_r);
  c_temp_on: cover property ($rose(o_temp_sensor_en));
  c_wake: cover property (o_wake_request);
  c_bank_write: cover property (wr_en && (addr == `RTS_OFS_TEST_SETTING_0));

endmodule
`default_nettype wire

// ==== dv/rts_host_model.sv ====
`include "rts_defines.svh"
`default_nettype none
module rts_host_model
  import rts_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_miso,
  input  wire logic i_miso_oe_n,
  output logic      o_chip_select_low,
  output logic      o_sclk,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 100ps;

  logic miso_last = 1'b0;
  logic miso_line;

  // ----------------------------------------------------------------
  // Released data line
  // ----------------------------------------------------------------
  // No pull on the line: an undriven read shows the inverse, never a stale hold
  always @(posedge i_clk_sys) if (!i_miso_oe_n) miso_last <= i_miso;
  assign miso_line = i_miso_oe_n ? ~miso_last : i_miso;

  initial begin
    o_chip_select_low = 1'b1;
    o_sclk            = 1'b0;
    o_mosi            = 1'b0;
  end

  // ----------------------------------------------------------------
  // One header plus one data byte, MSB first, each level four clocks
  // ----------------------------------------------------------------
  task automatic frame(input rts_byte_t hdr, input rts_byte_t dat, output rts_byte_t st, output rts_byte_t rd);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {hdr, dat};
    rx = '0;
    // Factory-only registers are never written: such a request becomes a read
    if (!tx[15] && (tx[13:8] == `RTS_OFS_SYNTH_TEST || tx[13:8] == `RTS_OFS_GAIN_CTRL_TEST)) tx[15] = 1'b1;
    @(negedge i_clk_sys);
    o_chip_select_low = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = tx[i];
      repeat (4) @(negedge i_clk_sys);
      rx[i] = miso_line;
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk_sys);
    o_chip_select_low = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    st = rx[15:8];
    rd = rx[7:0];
  endtask
endmodule
`default_nettype wire

// ==== dv/rts_regs_bench.sv ====
`include "rts_defines.svh"
`default_nettype none
module rts_regs_bench
  import rts_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk_sys;
  logic       resetn;
  logic       cs_low;
  logic       sclk;
  logic       mosi;
  logic       miso;
  logic       miso_oe_n;
  logic [4:0] state_code;
  logic       sleep_enter;
  rts_byte_t  freq_offset;
  logic       ask_ook;
  logic       crc_done;
  logic       crc_match;
  logic       rx_enter;
  logic       lqi_valid;
  logic [6:0] lqi_value;
  rts_byte_t  signal_strength;
  logic       wake;
  logic       temp_en;
  logic       osc_en;
  int         failures;
  int         num_checks;
  int         wakes;

  rts_regs u_rts_regs (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_chip_select_low(cs_low), .i_sclk(sclk),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n), .i_radio_state_code(state_code),
    .i_sleep_enter(sleep_enter), .i_freq_offset(freq_offset), .i_mod_ask_ook(ask_ook),
    .i_crc_done(crc_done), .i_crc_match(crc_match), .i_rx_enter(rx_enter), .i_lqi_valid(lqi_valid),
    .i_link_quality_value(lqi_value), .i_signal_strength(signal_strength), .o_wake_request(wake),
    .o_temp_sensor_en(temp_en), .o_osc_select_cal_enable(osc_en));

  rts_host_model u_rts_host_model (
    .i_clk_sys(clk_sys), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
    .o_chip_select_low(cs_low), .o_sclk(sclk), .o_mosi(mosi));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Counted off the falling edge, opposite the launching edge, so the pulse is seen settled
  always @(negedge clk_sys) if (wake === 1'b1) wakes++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check8(input rts_byte_t got, input rts_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] addr, input rts_byte_t dat);
    rts_byte_t st;
    rts_byte_t rd;
    u_rts_host_model.frame({2'b00, addr}, dat, st, rd);
  endtask

  task automatic read_chk(input logic [5:0] addr, input rts_byte_t exp);
    rts_byte_t st;
    rts_byte_t rd;
    u_rts_host_model.frame({2'b10, addr}, 8'h00, st, rd);
    check8(rd, exp);
  endtask

  task automatic pulse_clk();
    @(negedge clk_sys);
    {sleep_enter, crc_done, rx_enter, lqi_valid} = '0;
    repeat (2) @(negedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rts_byte_t exp [6] = '{8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B};
    for (int i = 0; i < 6; i++) read_chk(6'h29 + 6'(i), exp[i]);
    check8({7'h0, osc_en}, 8'h01);
  endtask

  task automatic t_sleep_restore();
    wr(`RTS_OFS_TEST_SETTING_2, 8'h12);
    wr(`RTS_OFS_TEST_SETTING_0, 8'h09);
    check8({7'h0, osc_en}, 8'h00);
    read_chk(`RTS_OFS_TEST_SETTING_2, 8'h12);
    sleep_enter = 1'b1;
    pulse_clk();
    read_chk(`RTS_OFS_TEST_SETTING_2, 8'h88);
    read_chk(`RTS_OFS_TEST_SETTING_0, 8'h0B);
    check8({7'h0, osc_en}, 8'h01);
  endtask

  task automatic t_temp_sensor();
    state_code = `RTS_CODE_IDLE;
    wr(`RTS_OFS_PRODUCTION_TEST, 8'hBF);
    check8({7'h0, temp_en}, 8'h01);
    // Default goes back before any move out of idle
    wr(`RTS_OFS_PRODUCTION_TEST, 8'h7F);
    check8({7'h0, temp_en}, 8'h00);
  endtask

  task automatic t_ids_read_only();
    read_chk(`RTS_OFS_PART_NUMBER, 8'hA5);
    read_chk(`RTS_OFS_SILICON_VERSION, 8'h5A);
    wr(`RTS_OFS_PART_NUMBER, 8'h00);
    wr(`RTS_OFS_SIGNAL_STRENGTH, 8'hFF);
    read_chk(`RTS_OFS_PART_NUMBER, 8'hA5);
    // A status write must not alias onto a test register
    read_chk(`RTS_OFS_TEST_SETTING_2, `RTS_RST_TEST_SETTING_2);
    read_chk(6'h2F, 8'h00);
  endtask

  task automatic t_status();
    freq_offset = 8'hF3;
    signal_strength        = 8'h9C;
    read_chk(`RTS_OFS_FREQ_OFFSET, 8'hF3);
    ask_ook = 1'b1;
    read_chk(`RTS_OFS_FREQ_OFFSET, 8'h00);
    ask_ook = 1'b0;
    read_chk(`RTS_OFS_SIGNAL_STRENGTH, 8'h9C);
    {crc_done, crc_match, lqi_valid, lqi_value} = {3'b111, 7'h55};
    pulse_clk();
    read_chk(`RTS_OFS_LINK_QUALITY, 8'hD5);
    rx_enter = 1'b1;
    pulse_clk();
    read_chk(`RTS_OFS_LINK_QUALITY, 8'h55);
  endtask

  task automatic t_state_codes();
    logic [4:0] codes [7] = '{5'h01, 5'h0D, 5'h11, 5'h13, 5'h16, 5'h00, 5'h02};
    rts_byte_t  st;
    rts_byte_t  rd;
    int         w0;
    for (int i = 0; i < 7; i++) begin
      state_code = codes[i];
      w0         = wakes;
      u_rts_host_model.frame({2'b10, `RTS_OFS_RADIO_STATE}, 8'h00, st, rd);
      // Sleep and crystal-off wake on chip select and are reported as idle
      check8(rd, (i < 5) ? {3'b000, codes[i]} : 8'h01);
      check8(st, (i < 5) ? {3'b000, codes[i]} : 8'h01);
      check8(8'(wakes - w0), (i < 5) ? 8'h00 : 8'h01);
    end
    state_code = `RTS_CODE_IDLE;
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end

  initial begin
    {resetn, state_code, sleep_enter, freq_offset, ask_ook} = {1'b0, 5'h01, 1'b0, 8'h00, 1'b0};
    {crc_done, crc_match, rx_enter, lqi_valid, lqi_value, signal_strength} = '0;
    {failures, num_checks, wakes} = '0;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset_values();
    t_sleep_restore();
    t_temp_sensor();
    t_ids_read_only();
    t_status();
    t_state_codes();
    wrap_up();
  end
endmodule
`default_nettype wire
